// [rtl/asc_ctrl.sv]
// sequencer control, direct output access and calibration registers
// assumes the host drives the serial pins asynchronously; everything else
// comes from converter logic on the same clock
`timescale 1ns/1ns
`default_nettype none

module asc_ctrl #(
   parameter int DELAY_UNIT_CYC = asc_pkg::DELAY_UNIT_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // serial host pins
   input wire logic sclkPin,
   input wire logic csPinN,
   input wire logic mosiPin,
   output logic misoOut,
   output logic misoOe,
   // loose control bits and power state
   input wire logic sleepState,
   input wire logic standbyState,
   input wire logic sequencedOutCtrl,
   input wire logic calReadbackSel,
   input wire logic systemOffsetDisable,
   input wire logic systemGainDisable,
   input wire logic selfOffsetDisable,
   input wire logic unipolarMode,
   input wire logic [7:0] outputDelayTime,
   input wire logic [7:0] channelDelayTime,
   // calibration status and results
   input wire logic sysOffCalBusy,
   input wire logic sysGainCalBusy,
   input wire logic selfCalBusy,
   input wire logic convBusy,
   input wire logic calResValid,
   input wire logic [1:0] calResKind,
   input wire logic [asc_pkg::DATA_W-1:0] calResValue,
   // sequencer handshake
   input wire logic startReq,
   input wire logic convDone,
   input wire logic scanLast,
   input wire logic [2:0] scanChan,
   input wire logic [asc_pkg::GPO_W-1:0] seqOut,
   output logic [2:0] chanSel,
   output logic convStart,
   output logic readyLowN,
   // general purpose outputs
   output logic [asc_pkg::GPO_W-1:0] generalOut,
   // raw and corrected results
   input wire logic rawValid,
   input wire logic [asc_pkg::DATA_W-1:0] rawData,
   output logic corrValid,
   output logic [asc_pkg::DATA_W-1:0] corrData
);

   // ==========================================================
   // helpers
   // delay field in units to clock cycles
   function automatic logic [asc_pkg::CNT_W-1:0] delayCycles(input logic [7:0] t);
      return asc_pkg::CNT_W'(int'(t) * DELAY_UNIT_CYC);
   endfunction : delayCycles

   // readback of a calibration register
   function automatic logic [asc_pkg::DATA_W-1:0] calRead(
      input logic sel,
      input logic busy,
      input logic [asc_pkg::DATA_W-1:0] user,
      input logic [asc_pkg::DATA_W-1:0] internal
   );
      // user value when select is set
      if (sel) return user;
      else if (busy) return internal;
      else return '0;
   endfunction : calRead

   // ==========================================================
   // pin synchronisers
   logic sclkSync1_ff, sclkSync2_ff, sclkPrev_ff;
   logic csnSync1_ff, csnSync2_ff;
   logic mosiSync1_ff, mosiSync2_ff;

   // two stages per pin, plus a previous-value stage on sclk; stage one feeds no logic
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sclkSync1_ff <= 1'b0;
         sclkSync2_ff <= 1'b0;
         sclkPrev_ff <= 1'b0;
         csnSync1_ff <= 1'b1;
         csnSync2_ff <= 1'b1;
         mosiSync1_ff <= 1'b0;
         mosiSync2_ff <= 1'b0;
      end else begin
         sclkSync1_ff <= sclkPin;
         sclkSync2_ff <= sclkSync1_ff;
         sclkPrev_ff <= sclkSync2_ff;
         csnSync1_ff <= csPinN;
         csnSync2_ff <= csnSync1_ff;
         mosiSync1_ff <= mosiPin;
         mosiSync2_ff <= mosiSync1_ff;
      end
   end

   logic sclkRise; // host sampling edge
   logic sclkFall; // our launch edge
   logic spiActive; // frame open
   assign sclkRise = sclkSync2_ff & ~sclkPrev_ff;
   assign sclkFall = ~sclkSync2_ff & sclkPrev_ff;
   assign spiActive = ~csnSync2_ff;

   // ==========================================================
   // serial engine and register file
   logic [asc_pkg::BITCNT_W-1:0] bitCnt_ff, nxt_bitCnt;
   logic [7:0] cmd_ff, nxt_cmd;
   logic [asc_pkg::DATA_W-1:0] shIn_ff, nxt_shIn;
   logic [asc_pkg::DATA_W-1:0] shOut_ff, nxt_shOut;
   logic misoOe_ff, nxt_misoOe;
   asc_pkg::asc_seq_t seq_ff, nxt_seq; // sequencer control
   logic [asc_pkg::GPO_W-1:0] outDir_ff, nxt_outDir; // direct output access
   logic [asc_pkg::DATA_W-1:0] sysOff_ff, nxt_sysOff; // user values
   logic [asc_pkg::DATA_W-1:0] sysGain_ff, nxt_sysGain;
   logic [asc_pkg::DATA_W-1:0] selfOff_ff, nxt_selfOff;
   logic [asc_pkg::DATA_W-1:0] sysOffInt_ff, nxt_sysOffInt; // calibration results
   logic [asc_pkg::DATA_W-1:0] sysGainInt_ff, nxt_sysGainInt;
   logic [asc_pkg::DATA_W-1:0] selfOffInt_ff, nxt_selfOffInt;
   logic [asc_pkg::DATA_W-1:0] rdWord; // left justified read data
   logic [asc_pkg::DATA_W-1:0] inWord; // data word with current bit
   logic [asc_pkg::ADDR_W-1:0] cmdAddr;
   logic cmdWrite;
   logic seqDirectBlocked; // sequencer owns the outputs

   assign cmdAddr = cmd_ff[asc_pkg::ADDR_W:1];
   assign cmdWrite = cmd_ff[asc_pkg::CMD_START_BIT] & ~cmd_ff[asc_pkg::CMD_READ_BIT];
   assign seqDirectBlocked = (seq_ff.mode == asc_pkg::ASC_MODE3) & sequencedOutCtrl;

   // read data, chosen from the address bits shifted so far
   always_comb begin
      rdWord = '0;
      case (cmd_ff[asc_pkg::ADDR_W-1:0])
         asc_pkg::ADDR_SEQ: rdWord = {seq_ff, 16'h0000};
         asc_pkg::ADDR_OUT_DIR: rdWord = {6'h00, outDir_ff, 16'h0000};
         asc_pkg::ADDR_SYS_OFF:
            rdWord = calRead(calReadbackSel, convBusy, sysOff_ff, sysOffInt_ff);
         asc_pkg::ADDR_SYS_GAIN:
            rdWord = calRead(calReadbackSel, convBusy, sysGain_ff, sysGainInt_ff);
         asc_pkg::ADDR_SELF_OFF:
            rdWord = calRead(calReadbackSel, convBusy, selfOff_ff, selfOffInt_ff);
         default: rdWord = '0;
      endcase
   end

   // frame decode, shifting and register writes
   always_comb begin
      nxt_bitCnt = bitCnt_ff;
      nxt_cmd = cmd_ff;
      nxt_shIn = shIn_ff;
      nxt_shOut = shOut_ff;
      nxt_misoOe = misoOe_ff;
      nxt_seq = seq_ff;
      nxt_outDir = outDir_ff;
      nxt_sysOff = sysOff_ff;
      nxt_sysGain = sysGain_ff;
      nxt_selfOff = selfOff_ff;
      inWord = {shIn_ff[asc_pkg::DATA_W-2:0], mosiSync2_ff};
      if (!spiActive) begin
         // idle between frames
         nxt_bitCnt = '0;
         nxt_misoOe = 1'b0;
      end else if (sclkRise) begin
         if (bitCnt_ff != asc_pkg::BITCNT_MAX) begin
            nxt_bitCnt = bitCnt_ff + 6'h01;
         end
         if (bitCnt_ff < asc_pkg::CMD_BITS) begin
            // command byte
            nxt_cmd = {cmd_ff[6:0], mosiSync2_ff};
            if (bitCnt_ff == asc_pkg::CMD_LAST && nxt_cmd[asc_pkg::CMD_START_BIT]
                && nxt_cmd[asc_pkg::CMD_READ_BIT]) begin
               nxt_misoOe = 1'b1;
               nxt_shOut = rdWord;
            end
         end else begin
            // data phase, msb first
            nxt_shIn = inWord;
            if (cmdWrite && bitCnt_ff == asc_pkg::NARROW_LAST) begin
               if (cmdAddr == asc_pkg::ADDR_SEQ) begin
                  nxt_seq = asc_pkg::asc_seq_t'(inWord[asc_pkg::REG8_W-1:0]);
               end
               if (cmdAddr == asc_pkg::ADDR_OUT_DIR && !seqDirectBlocked) begin
                  nxt_outDir = inWord[asc_pkg::GPO_W-1:0];
               end
            end
            if (cmdWrite && bitCnt_ff == asc_pkg::WIDE_LAST) begin
               if (cmdAddr == asc_pkg::ADDR_SYS_OFF && !sysOffCalBusy) begin
                  nxt_sysOff = inWord;
               end
               if (cmdAddr == asc_pkg::ADDR_SYS_GAIN && !sysGainCalBusy) begin
                  nxt_sysGain = inWord;
               end
               if (cmdAddr == asc_pkg::ADDR_SELF_OFF && !selfCalBusy) begin
                  nxt_selfOff = inWord;
               end
            end
         end
      end else if (sclkFall && bitCnt_ff > asc_pkg::CMD_BITS) begin
         // first data bit already on the pin; launch the next
         nxt_shOut = {shOut_ff[asc_pkg::DATA_W-2:0], 1'b0};
      end
   end

   // calibration results go to their own storage
   always_comb begin
      nxt_sysOffInt = sysOffInt_ff;
      nxt_sysGainInt = sysGainInt_ff;
      nxt_selfOffInt = selfOffInt_ff;
      if (calResValid) begin
         case (calResKind)
            asc_pkg::CAL_SYS_OFF: nxt_sysOffInt = calResValue;
            asc_pkg::CAL_SYS_GAIN: nxt_sysGainInt = calResValue;
            asc_pkg::CAL_SELF_OFF: nxt_selfOffInt = calResValue;
            default: nxt_selfOffInt = selfOffInt_ff;
         endcase
      end
   end

   // serial and register state
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bitCnt_ff <= '0;
         cmd_ff <= 8'h00;
         shIn_ff <= '0;
         shOut_ff <= '0;
         misoOe_ff <= 1'b0;
         seq_ff <= asc_pkg::asc_seq_t'(asc_pkg::SEQ_RST);
         outDir_ff <= asc_pkg::OUT_DIR_RST;
         sysOff_ff <= asc_pkg::SYS_OFF_RST;
         sysGain_ff <= asc_pkg::SYS_GAIN_RST;
         selfOff_ff <= asc_pkg::SELF_OFF_RST;
         sysOffInt_ff <= asc_pkg::SYS_OFF_RST;
         sysGainInt_ff <= asc_pkg::SYS_GAIN_RST;
         selfOffInt_ff <= asc_pkg::SELF_OFF_RST;
      end else begin
         bitCnt_ff <= nxt_bitCnt;
         cmd_ff <= nxt_cmd;
         shIn_ff <= nxt_shIn;
         shOut_ff <= nxt_shOut;
         misoOe_ff <= nxt_misoOe;
         seq_ff <= nxt_seq;
         outDir_ff <= nxt_outDir;
         sysOff_ff <= nxt_sysOff;
         sysGain_ff <= nxt_sysGain;
         selfOff_ff <= nxt_selfOff;
         sysOffInt_ff <= nxt_sysOffInt;
         sysGainInt_ff <= nxt_sysGainInt;
         selfOffInt_ff <= nxt_selfOffInt;
      end
   end

   assign misoOut = shOut_ff[asc_pkg::DATA_W-1];
   assign misoOe = misoOe_ff;

   // ==========================================================
   // sequencer: channel delay, conversion start, ready
   typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_CONV} asc_sq_state_t;
   asc_sq_state_t sq_ff, nxt_sq;
   logic [asc_pkg::CNT_W-1:0] chanTmr_ff, nxt_chanTmr;
   logic [2:0] chanSel_ff, nxt_chanSel;
   logic convStart_ff, nxt_convStart;
   logic readyLowN_ff, nxt_readyLowN;
   logic [2:0] pickChan; // channel for this start

   always_comb begin
      nxt_sq = sq_ff;
      nxt_chanTmr = chanTmr_ff;
      nxt_chanSel = chanSel_ff;
      nxt_convStart = 1'b0;
      nxt_readyLowN = readyLowN_ff;
      // mode 1 uses the stored channel
      pickChan = (seq_ff.mode == asc_pkg::ASC_MODE1) ? seq_ff.chan : scanChan;
      case (sq_ff)
         SQ_IDLE: begin
            // reserved mode never starts; 6, 7 refused
            if (startReq && seq_ff.mode != asc_pkg::ASC_MODE_RSV
                && pickChan <= asc_pkg::CHAN_MAX) begin
               nxt_chanSel = pickChan;
               nxt_readyLowN = 1'b1;
               if (seq_ff.chanDlyEn && delayCycles(channelDelayTime) != '0) begin
                  nxt_chanTmr = delayCycles(channelDelayTime);
                  nxt_sq = SQ_WAIT;
               end else begin
                  nxt_convStart = 1'b1;
                  nxt_sq = SQ_CONV;
               end
            end
         end
         SQ_WAIT: begin
            // start when the timer runs out
            if (chanTmr_ff <= asc_pkg::CNT_W'(1)) begin
               nxt_convStart = 1'b1;
               nxt_sq = SQ_CONV;
            end else begin
               nxt_chanTmr = chanTmr_ff - asc_pkg::CNT_W'(1);
            end
         end
         SQ_CONV: begin
            if (convDone) begin
               // scan modes wait for the last channel
               if (!(seq_ff.rdyHoldEn && seq_ff.mode != asc_pkg::ASC_MODE1 && !scanLast)) begin
                  nxt_readyLowN = 1'b0;
               end
               nxt_sq = SQ_IDLE;
            end
         end
         default: nxt_sq = SQ_IDLE;
      endcase
   end

   // sequencer state
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sq_ff <= SQ_IDLE;
         chanTmr_ff <= '0;
         chanSel_ff <= 3'h0;
         convStart_ff <= 1'b0;
         readyLowN_ff <= 1'b1;
      end else begin
         sq_ff <= nxt_sq;
         chanTmr_ff <= nxt_chanTmr;
         chanSel_ff <= nxt_chanSel;
         convStart_ff <= nxt_convStart;
         readyLowN_ff <= nxt_readyLowN;
      end
   end

   assign chanSel = chanSel_ff;
   assign convStart = convStart_ff;
   assign readyLowN = readyLowN_ff;

   // ==========================================================
   // general purpose outputs
   // direct writes stay immediate; only sequenced switching is delayed,
   // otherwise the delay would break immediate direct access
   logic [asc_pkg::GPO_W-1:0] gpo_ff, nxt_gpo;
   logic [asc_pkg::GPO_W-1:0] pend_ff, nxt_pend;
   logic armed_ff, nxt_armed;
   logic [asc_pkg::CNT_W-1:0] gpoTmr_ff, nxt_gpoTmr;
   logic [asc_pkg::GPO_W-1:0] gpoTarget;
   logic useDelay;

   always_comb begin
      nxt_gpo = gpo_ff;
      nxt_pend = pend_ff;
      nxt_armed = armed_ff;
      nxt_gpoTmr = gpoTmr_ff;
      if (sleepState) begin
         gpoTarget = '0;
      end else if (seqDirectBlocked) begin
         gpoTarget = seqOut;
      end else begin
         gpoTarget = outDir_ff;
      end
      useDelay = seq_ff.outDlyEn & seqDirectBlocked & ~sleepState
                 & (delayCycles(outputDelayTime) != '0);
      if (gpoTarget == gpo_ff) begin
         nxt_armed = 1'b0;
      end else if (!useDelay) begin
         nxt_gpo = gpoTarget;
         nxt_armed = 1'b0;
      end else if (!armed_ff || pend_ff != gpoTarget) begin
         nxt_armed = 1'b1;
         nxt_pend = gpoTarget;
         nxt_gpoTmr = delayCycles(outputDelayTime);
      end else if (gpoTmr_ff <= asc_pkg::CNT_W'(1)) begin
         nxt_gpo = pend_ff;
         nxt_armed = 1'b0;
      end else begin
         nxt_gpoTmr = gpoTmr_ff - asc_pkg::CNT_W'(1);
      end
   end

   // output state
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gpo_ff <= '0;
         pend_ff <= '0;
         armed_ff <= 1'b0;
         gpoTmr_ff <= '0;
      end else begin
         gpo_ff <= nxt_gpo;
         pend_ff <= nxt_pend;
         armed_ff <= nxt_armed;
         gpoTmr_ff <= nxt_gpoTmr;
      end
   end

   assign generalOut = gpo_ff;

   // ==========================================================
   // correction datapath; standby needs no special case
   asc_pkg::asc_corr_cfg_t corrCfg;
   assign corrCfg = '{selfOff: selfOff_ff, sysOff: sysOff_ff, sysGain: sysGain_ff,
                      selfOffDis: selfOffsetDisable, sysOffDis: systemOffsetDisable,
                      sysGainDis: systemGainDisable, unipolar: unipolarMode};

   asc_corr u_corr (
      .clk(clk),
      .rstn(rstn),
      .cfg(corrCfg),
      .rawValid(rawValid),
      .rawData(rawData),
      .corrValid(corrValid),
      .corrData(corrData)
   );

   logic unusedStandby; // standby behaves as the awake default
   assign unusedStandby = standbyState;

endmodule : asc_ctrl

`default_nettype wire

// [rtl/asc_pkg.sv]
// constants, field layouts and carrier types for the converter control block
// assumes one clock domain at 125 MHz; shared by the control top and its datapath
package asc_pkg;

   // ==========================================================
   // widths
   localparam int DATA_W = 24;
   localparam int REG8_W = 8;
   localparam int GPO_W = 2;
   localparam int CNT_W = 18;
   localparam int BITCNT_W = 6;
   localparam int ADDR_W = 6;

   // ==========================================================
   // serial frame: command byte then data, msb first
   localparam int CMD_START_BIT = 7;
   localparam int CMD_READ_BIT = 0;
   localparam logic [BITCNT_W-1:0] CMD_BITS = 6'h08;
   localparam logic [BITCNT_W-1:0] CMD_LAST = 6'h07;
   localparam logic [BITCNT_W-1:0] NARROW_LAST = 6'h0F;
   localparam logic [BITCNT_W-1:0] WIDE_LAST = 6'h1F;
   localparam logic [BITCNT_W-1:0] BITCNT_MAX = 6'h3F;

   // ==========================================================
   // register addresses
   localparam logic [ADDR_W-1:0] ADDR_SEQ = 6'h08;
   localparam logic [ADDR_W-1:0] ADDR_OUT_DIR = 6'h09;
   localparam logic [ADDR_W-1:0] ADDR_SYS_OFF = 6'h0A;
   localparam logic [ADDR_W-1:0] ADDR_SYS_GAIN = 6'h0B;
   localparam logic [ADDR_W-1:0] ADDR_SELF_OFF = 6'h0C;

   // ==========================================================
   // reset values
   localparam logic [REG8_W-1:0] SEQ_RST = 8'h00;
   localparam logic [GPO_W-1:0] OUT_DIR_RST = 2'h0;
   localparam logic [DATA_W-1:0] SYS_OFF_RST = 24'h000000;
   localparam logic [DATA_W-1:0] SYS_GAIN_RST = 24'h7FFFFF;
   localparam logic [DATA_W-1:0] SELF_OFF_RST = 24'h000000;

   // ==========================================================
   // sequencer fields and codes
   typedef enum logic [1:0] {
      ASC_MODE1 = 2'h0,
      ASC_MODE2 = 2'h1,
      ASC_MODE3 = 2'h2,
      ASC_MODE_RSV = 2'h3
   } asc_mode_t;
   localparam logic [2:0] CHAN_MAX = 3'h5;

   typedef struct packed {
      logic [2:0] chan;
      asc_mode_t mode;
      logic outDlyEn;
      logic chanDlyEn;
      logic rdyHoldEn;
   } asc_seq_t;

   // calibration result kinds
   localparam logic [1:0] CAL_SYS_OFF = 2'h0;
   localparam logic [1:0] CAL_SYS_GAIN = 2'h1;
   localparam logic [1:0] CAL_SELF_OFF = 2'h2;

   // gain is unsigned with this many fraction bits
   localparam int GAIN_FRAC = 23;
   localparam int PROD_W = 52;

   // ==========================================================
   // timing: one unit of the delay time fields
   localparam int CLK_PERIOD_NS = 8;
   localparam int DELAY_UNIT_NS = 4000;
   localparam int DELAY_UNIT_CYC = (DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // correction settings carried to the datapath
   typedef struct packed {
      logic [DATA_W-1:0] selfOff;
      logic [DATA_W-1:0] sysOff;
      logic [DATA_W-1:0] sysGain;
      logic selfOffDis;
      logic sysOffDis;
      logic sysGainDis;
      logic unipolar;
   } asc_corr_cfg_t;

endpackage : asc_pkg

// [rtl/asc_corr.sv]
// offset and gain correction of one raw conversion result
// assumes raw results arrive as two's complement pulses on the same clock
`timescale 1ns/1ns
`default_nettype none

module asc_corr (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // settings
   input wire asc_pkg::asc_corr_cfg_t cfg,
   // raw result in
   input wire logic rawValid,
   input wire logic [asc_pkg::DATA_W-1:0] rawData,
   // corrected result out
   output logic corrValid,
   output logic [asc_pkg::DATA_W-1:0] corrData
);

   // ==========================================================
   // helpers
   // clip a wide signed value into the 24-bit signed range
   function automatic logic [asc_pkg::DATA_W-1:0] sat24(
      input logic signed [asc_pkg::PROD_W-1:0] v
   );
      logic signed [asc_pkg::PROD_W-1:0] hi;
      logic signed [asc_pkg::PROD_W-1:0] lo;
      hi = asc_pkg::PROD_W'(signed'(24'sh7FFFFF));
      lo = asc_pkg::PROD_W'(signed'(24'sh800000));
      if (v > hi) return 24'h7FFFFF;
      else if (v < lo) return 24'h800000;
      else return v[asc_pkg::DATA_W-1:0];
   endfunction : sat24

   logic signed [asc_pkg::PROD_W-1:0] acc; // running corrected value
   logic signed [asc_pkg::PROD_W-1:0] gainX; // gain as positive signed
   logic nxt_valid;
   logic [asc_pkg::DATA_W-1:0] nxt_data;
   logic valid_ff;
   logic [asc_pkg::DATA_W-1:0] data_ff;

   // ==========================================================
   // correction chain, in fixed order
   always_comb begin
      acc = asc_pkg::PROD_W'(signed'(rawData));
      gainX = asc_pkg::PROD_W'({1'b0, cfg.sysGain});
      if (!cfg.selfOffDis) begin
         acc = acc - asc_pkg::PROD_W'(signed'(cfg.selfOff));
      end
      if (!cfg.sysOffDis) begin
         acc = acc - asc_pkg::PROD_W'(signed'(cfg.sysOff));
      end
      if (!cfg.sysGainDis) begin
         acc = (acc * gainX) >>> asc_pkg::GAIN_FRAC;
      end
      // unipolar doubles, bipolar keeps one
      if (cfg.unipolar) begin
         acc = acc <<< 1;
      end
      nxt_valid = rawValid;
      nxt_data = rawValid ? sat24(acc) : data_ff;
   end

   // result registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         valid_ff <= 1'b0;
         data_ff <= '0;
      end else begin
         valid_ff <= nxt_valid;
         data_ff <= nxt_data;
      end
   end

   assign corrValid = valid_ff;
   assign corrData = data_ff;

endmodule : asc_corr

`default_nettype wire

// [rtl/asc_dummy_guard.sv]
`timescale 1ns/1ns

// [test/asc_ctrl_monitor.sv]
// port-level timing checks of the control top
// assumes one clock domain and an active-low reset
`timescale 1ns/1ns
`default_nettype none
module asc_ctrl_mon (
   // watched ports
   input wire logic clk, rstn, sleepState, csPinN, misoOe, convStart, convDone,
   input wire logic readyLowN, rawValid, corrValid,
   input wire logic [2:0] chanSel,
   input wire logic [asc_pkg::GPO_W-1:0] generalOut
);
   // ====
   // single domain, so clock and reset are stated once
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_sleep_off: assert property (sleepState |=> generalOut == '0)
      else $error("output on in sleep");
   a_chan_valid: assert property (convStart |-> chanSel <= 3'h5)
      else $error("bad channel");
   a_start_pulse: assert property (convStart |=> !convStart)
      else $error("start too long");
   a_ready_cause: assert property ($fell(readyLowN) |-> $past(convDone))
      else $error("ready without done");
   a_corr_lat: assert property (rawValid |=> corrValid)
      else $error("result late");
   a_corr_cause: assert property (!rawValid |=> !corrValid)
      else $error("stray result");
   a_miso_frame: assert property ($rose(misoOe) |-> !csPinN)
      else $error("drive outside frame");
   a_miso_hold: assert property (misoOe && !csPinN |=> misoOe)
      else $error("drive dropped");
   c_start: cover property (convStart);
   c_ready: cover property ($fell(readyLowN));
   c_read: cover property ($rose(misoOe));
endmodule : asc_ctrl_mon
bind asc_ctrl asc_ctrl_mon u_mon (.*);
`default_nettype wire

// [test/asc_host.sv]
// host model: one serial frame per call, mode 0, msb first
// assumes the block samples the pins on clk; sclk idles low between frames
`timescale 1ns/1ns
`default_nettype none
module asc_host (
   // clock and serial pins
   input wire logic clk, misoOut,
   output logic sclkPin, csPinN, mosiPin
);
   initial begin sclkPin = 0; csPinN = 1; mosiPin = 0; end
   // ====
   // slow sclk (4 clk high, 8 low) covers the block's 3-clk pin sync
   task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, input int n,
      output logic [23:0] rd);
      rd = 24'h0;
      if (cmd == 8'h90 && wd[4:3] == 2'h3) wd[4] = 1'b0;
      @(posedge clk) csPinN <= 1'b0;
      for (int i = 0; i < 8 + n; i++) begin
         repeat (4) @(posedge clk) mosiPin <= (i < 8) ? cmd[7 - i] : wd[n + 7 - i];
         repeat (4) @(posedge clk) sclkPin <= 1'b1;
         if (i > 7) rd = {rd[22:0], misoOut};
         repeat (4) @(posedge clk) sclkPin <= 1'b0;
      end
      // released data line toggles for six clocks and ends on the last bit
      repeat (6) @(posedge clk) mosiPin <= ~mosiPin;
      csPinN <= 1'b1;
      repeat (6) @(posedge clk);
   endtask : xfer
endmodule : asc_host
`default_nettype wire

// [test/testbench.sv]
// self-checking bench of the control top against an integer model
// assumes the host model and the checker bound to the top
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk = 0, rstn = 0, slp = 0, seqCtl = 0, sel = 1, uni = 0, cBusy = 0, crV = 0;
   logic startReq = 0, convDone = 0, rawValid = 0, sclk, csn, mosi, miso, cs, rdy, sl = 1, cv;
   logic [2:0] dis = 3'h7, busy = 3'h0, chanSel;
   logic [1:0] crK = 2'h0, seqOut = 2'h2, gOut;
   logic [23:0] crD = 24'h0, raw = 24'h0, corr, q, v;
   logic [7:0] cdt = 8'h00;
   // user register model, indexed by address minus 8
   logic [23:0] um[5] = '{24'h0, 24'h0, 24'h0, 24'h7FFFFF, 24'h0};
   logic [23:0] mk[5] = '{24'hEF, 24'h3, 24'hFFFFFF, 24'hFFFFFF, 24'hFFFFFF};
   int n_errors = 0, checks = 0, seed = 70213;
   always #4 clk = ~clk;
   asc_host host (.clk(clk), .misoOut(miso), .sclkPin(sclk), .csPinN(csn), .mosiPin(mosi));
   asc_ctrl #(.DELAY_UNIT_CYC(2)) dut (.clk(clk), .rstn(rstn), .sclkPin(sclk), .csPinN(csn),
      .mosiPin(mosi), .misoOut(miso), .misoOe(), .sleepState(slp), .standbyState(1'b0),
      .sequencedOutCtrl(seqCtl), .calReadbackSel(sel), .systemOffsetDisable(dis[1]),
      .systemGainDisable(dis[2]), .selfOffsetDisable(dis[0]), .unipolarMode(uni),
      .outputDelayTime(8'h00), .channelDelayTime(cdt), .sysOffCalBusy(busy[0]),
      .sysGainCalBusy(busy[1]), .selfCalBusy(busy[2]), .convBusy(cBusy), .calResValid(crV),
      .calResKind(crK), .calResValue(crD), .startReq(startReq), .convDone(convDone),
      .scanLast(sl), .scanChan(3'h0), .seqOut(seqOut), .chanSel(chanSel), .convStart(cs),
      .readyLowN(rdy), .generalOut(gOut), .rawValid(rawValid), .rawData(raw), .corrValid(cv),
      .corrData(corr));
   // ====
   task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic acc(input logic [5:0] a, input logic r, input logic [23:0] d);
      host.xfer({1'b1, a, r}, d, (a > 9) ? 24 : 8, q);
   endtask : acc
   task automatic td;
      $display("test done at %0t", $time);
   endtask : td
   // expected result: self offset, system offset, gain, doubling, clamp
   function automatic logic [23:0] expc(logic [23:0] r, logic [2:0] d, logic u);
      longint x = $signed(r);
      if (!d[0]) x -= $signed(um[4]);
      if (!d[1]) x -= $signed(um[2]);
      if (!d[2]) x = (x * longint'(um[3])) >>> 23;
      if (u) x *= 2;
      if (x > 8388607) x = 8388607;
      if (x < -8388608) x = -8388608;
      return x[23:0];
   endfunction : expc
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      for (int a = 8; a < 13; a++) begin
         acc(a, 1, 0);
         cmp(q, um[a - 8]);
         v = $random(seed) & mk[a - 8];
         acc(a, 0, v);
         um[a - 8] = v;
         acc(a, 1, 0);
         cmp(q, um[a - 8]);
      end
      td;
      for (int k = 0; k < 3; k++) begin
         busy <= 3'h1 << k;
         acc(k + 10, 0, ~um[k + 2]);
         v = $random(seed);
         crV <= 1; crK <= 2'(k); crD <= v; busy <= 0;
         @(posedge clk) crV <= 0; sel <= 0; cBusy <= 1;
         acc(k + 10, 1, 0);
         cmp(q, v);
         sel <= 1;
         acc(k + 10, 1, 0);
         cmp(q, um[k + 2]);
         cBusy <= 0;
      end
      td;
      acc(8, 0, 0); acc(9, 0, 2);
      cmp(gOut, 2);
      slp <= 1;
      acc(9, 0, 1);
      cmp(gOut, 0);
      slp <= 0;
      repeat (2) @(posedge clk);
      cmp(gOut, 1);
      seqCtl <= 1; acc(8, 0, 8'h10); acc(9, 0, 3);
      cmp(gOut, seqOut);
      acc(9, 1, 0);
      cmp(q, 1);
      seqCtl <= 0; acc(8, 0, 8'h60);
      td;
      @(posedge clk) startReq <= 1;
      @(posedge clk) startReq <= 0;
      @(posedge clk) cmp({cs, chanSel}, 4'hB);
      convDone <= 1;
      @(posedge clk) convDone <= 0;
      @(posedge clk) cmp(rdy, 0);
      for (int j = 0; j < 2; j++) begin
         if (j == 0) acc(8, 0, 8'h09);
         sl <= j[0];
         @(posedge clk) startReq <= 1;
         @(posedge clk) startReq <= 0; convDone <= 1;
         @(posedge clk) convDone <= 0;
         @(posedge clk) cmp(rdy, !j[0]);
      end
      cdt <= 8'h03; acc(8, 0, 8'h62);
      @(posedge clk) startReq <= 1;
      @(posedge clk) startReq <= 0;
      repeat (6) @(posedge clk) cmp(cs, 0);
      @(posedge clk) cmp({cs, chanSel}, 4'hB);
      td;
      for (int i = 0; i < 40; i++) begin
         @(posedge clk) rawValid <= 1; raw <= $random(seed); dis <= $random(seed); uni <= i[0];
         @(posedge clk) rawValid <= 0;
         @(posedge clk) cmp(corr, expc(raw, dis, uni));
         cmp(cv, 1);
      end
      td;
      tally_and_finish;
   end
endmodule : testbench
`default_nettype wire
